// ### design/dop_pkg.sv
// Shared constants for the DDS output path configuration block and its host.
// Contract
// RULE1 - Source select high feeds host data to DAC2
// RULE2 - Aux samples via either port, max 100 MHz
// RULE3 - Aux DAC path runs on system clock
// RULE4 - Aux DAC power-down bit acts alone
// RULE5 - Aux DAC path skips sinc compensation
// RULE6 - Sinc on after reset, bypass bit disables
// RULE7 - Five-bit field selects multiplier four to twenty
// RULE8 - System clock from multiplier or reference directly
// RULE9 - Multiplier bypass bit removes multiplier from path
// RULE10 - Host sets loop band by clock rate
// RULE11 - Differential select low single, high differential
// RULE12 - Power-down bit high powers stage down
// RULE13 - Output control bit high bypasses stage
// RULE14 - All four power-down bits give full power-down
// RULE15 - All registers writable and readable on both ports
// RULE16 - Port mode high parallel, low serial
// RULE17 - Writes buffered, transferred on update, clock-synchronous
// RULE18 - Port works without reference, transfer waits
// RULE19 - Internal update default, clear bit selects external
// RULE20 - Master reset held ten cycles, loads defaults
// RULE21 - Aux data reaches DAC after transfer only
package dop_pkg;
  localparam int NREG = 6;
  localparam int ADDR_W = 6;
  localparam logic [2:0] IDX_PD = 3'h0;
  localparam logic [2:0] IDX_CLK = 3'h1;
  localparam logic [2:0] IDX_UPD = 3'h2;
  localparam logic [2:0] IDX_OUT = 3'h3;
  localparam logic [2:0] IDX_AUXH = 3'h4;
  localparam logic [2:0] IDX_AUXL = 3'h5;
  localparam logic [NREG-1:0][ADDR_W-1:0] REG_ADDR = {6'h27, 6'h26, 6'h20, 6'h1F, 6'h1E, 6'h1D};
  localparam logic [NREG-1:0][7:0] REG_RST = {8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00};
  localparam int PD_DIG = 0;
  localparam int PD_IDAC = 1;
  localparam int PD_AUX = 2;
  localparam int PD_CMP = 3;
  localparam int CLK_MULT_LSB = 0;
  localparam int CLK_BYP = 5;
  localparam int CLK_RANGE = 6;
  localparam int UPD_INT = 0;
  localparam int UPD_AUXSRC = 4;
  localparam int OUT_AMPBYP = 5;
  localparam int OUT_SINCBYP = 6;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint AUX_MAX_HZ = 100_000_000;
  localparam int AUX_MIN_GAP_CYC = int'((CLK_HZ + AUX_MAX_HZ - 1) / AUX_MAX_HZ);
  localparam longint PLL_RANGE_HZ = 200_000_000;
  localparam logic [3:0] MRST_MIN_CYC = 4'hA;
  localparam logic [3:0] UPD_HIGH_CYC = 4'h8;
  localparam logic [31:0] UPD_N_DEF = 32'h0000001F;
  localparam logic [4:0] SER_LAST_BIT = 5'h0F;
  localparam logic [4:0] SER_HDR_LAST = 5'h07;
  localparam logic [11:0] HOST_CMD = 12'h000;
  localparam logic [11:0] HOST_STAT = 12'h004;
  localparam logic [11:0] HOST_CTRL = 12'h008;
endpackage

// ### design/dop_port_if.sv
// Host port, update strobe and strap signals between the DDS device and its host.
`timescale 1ns/100ps
`default_nettype none
interface dop_port_if;
  logic port_mode_select;
  logic differential_clock_select;
  logic master_reset;
  logic [5:0] par_addr;
  logic [7:0] par_wdata;
  logic par_wr;
  logic par_rd;
  logic [7:0] par_rdata;
  logic par_rvalid;
  logic ser_cs_n;
  logic ser_sclk;
  logic ser_sdi;
  logic ser_sdo;
  logic upd_dev_o;
  logic upd_dev_oe;
  logic upd_host_o;
  logic upd_host_oe;
  logic update_strobe_pin;

  // The update strobe wire: the device drives it when it enables, else the host when it enables, otherwise it idles low.
  assign update_strobe_pin = upd_dev_oe ? upd_dev_o : (upd_host_oe ? upd_host_o : 1'b0);

  modport device (
    input port_mode_select, differential_clock_select, master_reset,
    input par_addr, par_wdata, par_wr, par_rd, ser_cs_n, ser_sclk, ser_sdi,
    input update_strobe_pin,
    output par_rdata, par_rvalid, ser_sdo, upd_dev_o, upd_dev_oe
  );
  modport host (
    output port_mode_select, differential_clock_select, master_reset,
    output par_addr, par_wdata, par_wr, par_rd, ser_cs_n, ser_sclk, ser_sdi,
    output upd_host_o, upd_host_oe,
    input par_rdata, par_rvalid, ser_sdo, update_strobe_pin
  );
endinterface
`default_nettype wire

// ### design/dop_edge_sync.sv
// Two-stage synchroniser with rising-edge pulse for the update strobe.
`timescale 1ns/100ps
`default_nettype none
module dop_edge_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic rise_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } dop_sync_state_type;

  dop_sync_state_type state_q;
  dop_sync_state_type state_d;

  always_comb begin
    state_d.s1 = d_i;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    state_d.rise = state_q.s2 & ~state_q.s3;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rise_o = state_q.rise;
endmodule
`default_nettype wire

// ### design/dop_device.sv
// Device end: buffered configuration registers, update transfer and output controls.
//
// Chosen here: parallel and serial port access to the registers; the APB interface sits in dop_host.
`timescale 1ns/100ps
`default_nettype none
module dop_device #(
  parameter logic [31:0] UPD_N = dop_pkg::UPD_N_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  dop_port_if.device port,
  input wire logic ref_clock_present_i,
  input wire logic [11:0] synth_q_i,
  output logic [11:0] aux_dac_data_o,
  output logic aux_dac_pd_o,
  output logic [3:0] stage_pd_o,
  output logic full_pd_o,
  output logic sinc_i_en_o,
  output logic sinc_q_en_o,
  output logic amp_mult_bypass_o,
  output logic [4:0] mult_factor_o,
  output logic sysclk_from_mult_o,
  output logic loop_band_o,
  output logic transfer_o
);
  localparam logic [32:0] UPD_PERIOD_CYC = 33'({1'b0, UPD_N} + 33'h1) << 1;

  typedef struct packed {
    logic [dop_pkg::NREG-1:0][7:0] bufm;
    logic [dop_pkg::NREG-1:0][7:0] act;
    logic [32:0] upd_cnt;
    logic [3:0] hi_cnt;
    logic upd_oe;
    logic [7:0] rdata;
    logic rvalid;
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic [15:0] sh_in;
    logic [7:0] sh_out;
    logic [11:0] aux_data;
    logic aux_pd;
    logic [3:0] stage_pd;
    logic full_pd;
    logic sinc_i_en;
    logic sinc_q_en;
    logic amp_byp;
    logic [4:0] mult;
    logic sysclk_mult;
    logic loop_band;
    logic xfer;
  } dop_dev_state_type;

  dop_dev_state_type state_q;
  dop_dev_state_type state_d;
  logic ext_rise;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Returns {hit, index} for a port address.
  function automatic logic [3:0] decode(input logic [5:0] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < dop_pkg::NREG; i++) begin
      if (a == dop_pkg::REG_ADDR[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // Default state: register defaults and the output controls they imply.
  function automatic dop_dev_state_type init_state();
    dop_dev_state_type s;
    s = '0;
    s.bufm = dop_pkg::REG_RST;
    s.act = dop_pkg::REG_RST;
    s.upd_oe = 1'b1;
    s.sinc_i_en = 1'b1;
    s.sinc_q_en = 1'b1;
    s.mult = dop_pkg::MULT_MIN;
    s.sysclk_mult = 1'b1;
    return s;
  endfunction

  // ----------------------------------------------------------------------
  // External update strobe synchroniser
  // ----------------------------------------------------------------------
  dop_edge_sync u_upd_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(port.update_strobe_pin),
    .rise_o(ext_rise)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic [3:0] dec;
    logic trig;
    logic [4:0] m;
    logic [7:0] pd;
    logic [7:0] oc;
    logic [7:0] cc;
    logic [7:0] uc;
    dec = 4'h0;
    trig = 1'b0;
    m = 5'h0;
    pd = 8'h00;
    oc = 8'h00;
    cc = 8'h00;
    uc = 8'h00;
    state_d = state_q;
    state_d.rvalid = 1'b0;
    state_d.xfer = 1'b0;

    // Host port access touches only the buffer, never the active bank.
    if (port.port_mode_select) begin
      dec = decode(port.par_addr);
      if (port.par_wr && dec[3]) begin
        state_d.bufm[dec[2:0]] = port.par_wdata; // [RULE15] [RULE17] [RULE2]
      end
      if (port.par_rd) begin
        state_d.rvalid = 1'b1;
        state_d.rdata = dec[3] ? state_q.bufm[dec[2:0]] : 8'h00; // [RULE15]
      end
    end else if (port.ser_cs_n) begin
      state_d.bit_cnt = 5'h00;
      state_d.sh_out = 8'h00;
    end else if (port.ser_sclk && !state_q.sclk_prev) begin
      state_d.sh_in = {state_q.sh_in[14:0], port.ser_sdi};
      state_d.sh_out = {state_q.sh_out[6:0], 1'b0};
      state_d.bit_cnt = state_q.bit_cnt + 5'h01;
      if (state_q.bit_cnt == dop_pkg::SER_HDR_LAST) begin
        dec = decode(state_d.sh_in[5:0]);
        if (state_d.sh_in[7]) begin
          state_d.sh_out = dec[3] ? state_q.bufm[dec[2:0]] : 8'h00; // [RULE15]
        end
      end
      if (state_q.bit_cnt == dop_pkg::SER_LAST_BIT) begin
        dec = decode(state_d.sh_in[13:8]);
        if (!state_d.sh_in[15] && dec[3]) begin
          state_d.bufm[dec[2:0]] = state_d.sh_in[7:0]; // [RULE15] [RULE17] [RULE2]
        end
      end
    end
    state_d.sclk_prev = port.ser_sclk;

    // Update source: periodic internal counter or synchronised external edge.
    if (state_q.act[dop_pkg::IDX_UPD][dop_pkg::UPD_INT]) begin
      state_d.upd_oe = 1'b1;
      if (state_q.upd_cnt == 33'h0) begin
        state_d.upd_cnt = UPD_PERIOD_CYC - 33'h1;
        state_d.hi_cnt = dop_pkg::UPD_HIGH_CYC;
        trig = 1'b1; // [RULE19]
      end else begin
        state_d.upd_cnt = state_q.upd_cnt - 33'h1;
        if (state_q.hi_cnt != 4'h0) begin
          state_d.hi_cnt = state_q.hi_cnt - 4'h1;
        end
      end
    end else begin
      state_d.upd_oe = 1'b0;
      state_d.upd_cnt = 33'h0;
      state_d.hi_cnt = 4'h0;
      trig = ext_rise; // [RULE19]
    end

    // The whole buffer moves at once, and only while the reference runs.
    if (trig && ref_clock_present_i) begin
      state_d.act = state_q.bufm; // [RULE17] [RULE18] [RULE21]
      state_d.xfer = 1'b1;
    end

    if (port.master_reset) begin
      state_d = init_state(); // [RULE20]
    end

    // Output controls decoded from the next active bank.
    pd = state_d.act[dop_pkg::IDX_PD];
    cc = state_d.act[dop_pkg::IDX_CLK];
    uc = state_d.act[dop_pkg::IDX_UPD];
    oc = state_d.act[dop_pkg::IDX_OUT];
    state_d.stage_pd = pd[3:0]; // [RULE12]
    state_d.aux_pd = pd[dop_pkg::PD_AUX]; // [RULE4]
    state_d.full_pd = &pd[3:0]; // [RULE14]
    state_d.sinc_i_en = ~oc[dop_pkg::OUT_SINCBYP]; // [RULE6] [RULE13]
    state_d.sinc_q_en = ~oc[dop_pkg::OUT_SINCBYP] & ~uc[dop_pkg::UPD_AUXSRC]; // [RULE5]
    state_d.amp_byp = oc[dop_pkg::OUT_AMPBYP]; // [RULE13]
    m = cc[dop_pkg::CLK_MULT_LSB +: 5];
    if (m < dop_pkg::MULT_MIN) begin
      m = dop_pkg::MULT_MIN;
    end else if (m > dop_pkg::MULT_MAX) begin
      m = dop_pkg::MULT_MAX;
    end
    state_d.mult = m; // [RULE7]
    state_d.sysclk_mult = ~cc[dop_pkg::CLK_BYP]; // [RULE8] [RULE9]
    state_d.loop_band = cc[dop_pkg::CLK_RANGE];
    if (uc[dop_pkg::UPD_AUXSRC]) begin
      state_d.aux_data = {state_d.act[dop_pkg::IDX_AUXH][3:0],
                          state_d.act[dop_pkg::IDX_AUXL]}; // [RULE1] [RULE21]
    end else begin
      state_d.aux_data = synth_q_i; // [RULE1] [RULE3]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= init_state(); // [RULE6] [RULE19]
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign port.par_rdata = state_q.rdata;
  assign port.par_rvalid = state_q.rvalid;
  assign port.ser_sdo = state_q.sh_out[7];
  assign port.upd_dev_o = (state_q.hi_cnt != 4'h0);
  assign port.upd_dev_oe = state_q.upd_oe;
  assign aux_dac_data_o = state_q.aux_data;
  assign aux_dac_pd_o = state_q.aux_pd;
  assign stage_pd_o = state_q.stage_pd;
  assign full_pd_o = state_q.full_pd;
  assign sinc_i_en_o = state_q.sinc_i_en;
  assign sinc_q_en_o = state_q.sinc_q_en;
  assign amp_mult_bypass_o = state_q.amp_byp;
  assign mult_factor_o = state_q.mult;
  assign sysclk_from_mult_o = state_q.sysclk_mult;
  assign loop_band_o = state_q.loop_band;
  assign transfer_o = state_q.xfer;
endmodule
`default_nettype wire

// ### design/dop_host.sv
// Host end: APB-programmed controller driving the parallel or serial port.
`timescale 1ns/100ps
`default_nettype none
module dop_host #(
  parameter longint SYSCLK_HZ = 300_000_000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  dop_port_if.host port,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  localparam logic LOOP_BAND = (SYSCLK_HZ >= dop_pkg::PLL_RANGE_HZ);

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_PAR = 5'b00010,
    H_WAIT = 5'b00100,
    H_SER = 5'b01000,
    H_RST = 5'b10000
  } dop_hstate_type;

  typedef struct packed {
    dop_hstate_type st;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mode_par;
    logic diff_sel;
    logic ext_mode;
    logic [3:0] pulse_cnt;
    logic mr;
    logic [3:0] mr_cnt;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic cs_n;
    logic sclk;
    logic [15:0] sh;
    logic [4:0] bit_cnt;
  } dop_host_state_type;

  dop_host_state_type state_q;
  dop_host_state_type state_d;

  always_comb begin
    logic setup;
    logic acc;
    logic rd_cmd;
    logic [7:0] wd;
    setup = psel_i & ~penable_i;
    acc = psel_i & penable_i & state_q.pready;
    rd_cmd = pwdata_i[16];
    wd = pwdata_i[7:0];
    state_d = state_q;
    state_d.pready = setup;

    // APB read data is prepared in the setup cycle for the access cycle.
    if (setup) begin
      state_d.pslverr = 1'b0;
      case (paddr_i)
        dop_pkg::HOST_STAT: state_d.prdata = {15'h0000, port.update_strobe_pin,
                                              state_q.rdata, 7'h00, state_q.st != H_IDLE};
        dop_pkg::HOST_CTRL: state_d.prdata = {27'h0000000, state_q.ext_mode, 2'h0,
                                              state_q.diff_sel, state_q.mode_par};
        dop_pkg::HOST_CMD: state_d.prdata = {15'h0000, state_q.rd, 2'h0,
                                             state_q.addr, state_q.wdata};
        default: begin
          state_d.prdata = 32'h00000000;
          state_d.pslverr = 1'b1;
        end
      endcase
    end

    if (state_q.pulse_cnt != 4'h0) begin
      state_d.pulse_cnt = state_q.pulse_cnt - 4'h1;
    end

    case (state_q.st)
      H_IDLE: begin
        if (acc && pwrite_i && paddr_i == dop_pkg::HOST_CMD) begin
          if (pwdata_i[13:8] == dop_pkg::REG_ADDR[dop_pkg::IDX_CLK]) begin
            wd[dop_pkg::CLK_RANGE] = LOOP_BAND; // [RULE10]
          end
          state_d.addr = pwdata_i[13:8];
          state_d.wdata = wd;
          // The direction flags stand for the whole command; H_PAR gates the strobes.
          state_d.wr = ~rd_cmd; // [RULE2]
          state_d.rd = rd_cmd;
          if (state_q.mode_par) begin
            state_d.st = H_PAR;
          end else begin
            state_d.sh = {rd_cmd, 1'b0, pwdata_i[13:8], wd};
            state_d.cs_n = 1'b0;
            state_d.sclk = 1'b0;
            state_d.bit_cnt = 5'h00;
            state_d.st = H_SER;
          end
          state_d.rdata = rd_cmd ? 8'h00 : state_q.rdata;
        end else if (acc && pwrite_i && paddr_i == dop_pkg::HOST_CTRL) begin
          state_d.mode_par = pwdata_i[0]; // [RULE16]
          state_d.diff_sel = pwdata_i[1]; // [RULE11]
          state_d.ext_mode = pwdata_i[4];
          if (pwdata_i[3]) begin
            state_d.pulse_cnt = dop_pkg::UPD_HIGH_CYC;
          end
          if (pwdata_i[2]) begin
            state_d.mr = 1'b1;
            state_d.mr_cnt = 4'h0;
            state_d.st = H_RST;
          end
        end
      end
      H_PAR: begin
        state_d.st = state_q.rd ? H_WAIT : H_IDLE;
      end
      H_WAIT: begin
        if (port.par_rvalid) begin
          state_d.rdata = port.par_rdata;
          state_d.st = H_IDLE;
        end
      end
      H_SER: begin
        if (!state_q.sclk) begin
          state_d.sclk = 1'b1;
          if (state_q.bit_cnt > dop_pkg::SER_HDR_LAST && state_q.rd) begin
            state_d.rdata = {state_q.rdata[6:0], port.ser_sdo};
          end
        end else begin
          state_d.sclk = 1'b0;
          state_d.sh = {state_q.sh[14:0], 1'b0};
          state_d.bit_cnt = state_q.bit_cnt + 5'h01;
          if (state_q.bit_cnt == dop_pkg::SER_LAST_BIT) begin
            state_d.cs_n = 1'b1;
            state_d.st = H_IDLE;
          end
        end
      end
      H_RST: begin
        state_d.mr_cnt = state_q.mr_cnt + 4'h1;
        if (state_q.mr_cnt == dop_pkg::MRST_MIN_CYC - 4'h1) begin
          state_d.mr = 1'b0; // [RULE20]
          state_d.st = H_IDLE;
        end
      end
      default: begin
        state_d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '{st: H_IDLE, mode_par: 1'b1, cs_n: 1'b1, default: '0};
    end else begin
      state_q <= state_d;
    end
  end

  // In serial mode the header's top bit travels first on the data line.
  assign port.port_mode_select = state_q.mode_par;
  assign port.differential_clock_select = state_q.diff_sel;
  assign port.master_reset = state_q.mr;
  assign port.par_addr = state_q.addr;
  assign port.par_wdata = state_q.wdata;
  assign port.par_wr = state_q.wr & (state_q.st == H_PAR);
  assign port.par_rd = state_q.rd & (state_q.st == H_PAR);
  assign port.ser_cs_n = state_q.cs_n;
  assign port.ser_sclk = state_q.sclk;
  assign port.ser_sdi = state_q.sh[15];
  assign port.upd_host_o = (state_q.pulse_cnt != 4'h0);
  assign port.upd_host_oe = state_q.ext_mode;
  assign prdata_o = state_q.prdata;
  assign pready_o = state_q.pready;
  assign pslverr_o = state_q.pslverr;
endmodule
`default_nettype wire

// ### testbench/dop_asserts.sv
// Concurrent checks on the port interface and the device's configuration outputs.
`timescale 1ns/100ps
`default_nettype none
module dop_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic port_mode_select,
  input wire logic master_reset,
  input wire logic par_rd,
  input wire logic par_rvalid,
  input wire logic upd_dev_oe,
  input wire logic update_strobe_pin,
  input wire logic ref_clock_present_i,
  input wire logic transfer_o,
  input wire logic [3:0] stage_pd_o,
  input wire logic full_pd_o,
  input wire logic aux_dac_pd_o,
  input wire logic [4:0] mult_factor_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (par_rd && port_mode_select |=> par_rvalid)
    else $error("parallel read not answered");
  a_rvalid_cause: assert property (par_rvalid |-> $past(par_rd))
    else $error("read answer without request");
  a_transfer_ref: assert property (transfer_o |-> $past(ref_clock_present_i))
    else $error("transfer without reference clock");
  a_full_pd: assert property (full_pd_o == (&stage_pd_o))
    else $error("full power-down mismatch");
  a_aux_pd_alone: assert property (aux_dac_pd_o == stage_pd_o[dop_pkg::PD_AUX])
    else $error("aux DAC power-down mismatch");
  a_mult_range: assert property (mult_factor_o >= 5'h04 && mult_factor_o <= 5'h14)
    else $error("multiplier out of range");
  a_hold_till_xfer: assert property ($changed({stage_pd_o, mult_factor_o}) |->
    transfer_o || $past(master_reset))
    else $error("settings changed without transfer");
  a_mreset_len: assert property ($rose(master_reset) |-> master_reset[*8] ##1 master_reset[*2])
    else $error("master reset too short");
  a_int_pulse: assert property ($rose(update_strobe_pin) && upd_dev_oe |->
    (update_strobe_pin || !upd_dev_oe || master_reset)[*8])
    else $error("internal update pulse too short");
  a_ext_update: assert property ($rose(update_strobe_pin) && !upd_dev_oe && ref_clock_present_i
    |-> ##[1:6] transfer_o)
    else $error("external update not transferred");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench joining the host and device ends over the port interface.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i, rst_n_i, ref_on, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [11:0] aux_data;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] stage_pd;
  logic [4:0] mult;
  logic [7:0] q;
  logic aux_pd, full_pd, sinc_i, sinc_q, amp_byp, from_mult, band, transfer;
  int miscompares = 0;
  int checked = 0;
  dop_port_if pif ();
  dop_device #(.UPD_N(32'h00000007)) u_dop_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .port(pif), .ref_clock_present_i(ref_on), .synth_q_i(12'h123),
    .aux_dac_data_o(aux_data), .aux_dac_pd_o(aux_pd), .stage_pd_o(stage_pd),
    .full_pd_o(full_pd), .sinc_i_en_o(sinc_i), .sinc_q_en_o(sinc_q),
    .amp_mult_bypass_o(amp_byp), .mult_factor_o(mult), .sysclk_from_mult_o(from_mult),
    .loop_band_o(band), .transfer_o(transfer));
  dop_host u_dop_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .port(pif), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  dop_asserts u_dop_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .port_mode_select(pif.port_mode_select), .master_reset(pif.master_reset),
    .par_rd(pif.par_rd), .par_rvalid(pif.par_rvalid), .upd_dev_oe(pif.upd_dev_oe),
    .update_strobe_pin(pif.update_strobe_pin), .ref_clock_present_i(ref_on),
    .transfer_o(transfer), .stage_pd_o(stage_pd), .full_pd_o(full_pd),
    .aux_dac_pd_o(aux_pd), .mult_factor_o(mult));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic lost();
    chk("wait bound", 32'h0, 32'h1);
    complete_run();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) lost();
  endtask

  // Issues one device register access through the host and waits until it is done.
  task automatic hreg(input logic rd, input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, dop_pkg::HOST_CMD, {15'h0000, rd, 2'h0, a, d});
    do begin
      apb(1'b0, dop_pkg::HOST_STAT, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    q = r[15:8];
    if (r[0] !== 1'b0) lost();
  endtask

  task automatic wait_tr();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (transfer !== 1'b1 && n < 300);
    if (transfer !== 1'b1) lost();
  endtask

  task automatic upd(input logic [7:0] m);
    apb(1'b1, dop_pkg::HOST_CTRL, {24'h000000, m | 8'h10});
    apb(1'b1, dop_pkg::HOST_CTRL, {24'h000000, m | 8'h18});
    wait_tr();
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    ref_on = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < dop_pkg::NREG; i++) begin
      hreg(1'b1, dop_pkg::REG_ADDR[i], 8'h00);
      chk("reset reg", q, dop_pkg::REG_RST[i]);
    end
    hreg(1'b1, 6'h00, 8'h00);
    chk("unmapped reg", q, 8'h00);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("apb unmapped", rerr, 1'b1);
    chk("sinc reset", {sinc_i, sinc_q}, 2'h3);
    chk("mult reset", {from_mult, mult}, 6'h24);
    chk("aux internal", aux_data, 12'h123);
    $display("test reset done");
    hreg(1'b0, 6'h1F, 8'h00);
    wait_tr();
    repeat (20) @(posedge clk_i);
    hreg(1'b0, 6'h1D, 8'h0F);
    hreg(1'b0, 6'h20, 8'h60);
    hreg(1'b0, 6'h1E, 8'h25);
    chk("buffered pd", stage_pd, 4'h0);
    chk("buffered sinc", sinc_i, 1'b1);
    upd(8'h01);
    chk("pd all", {stage_pd, full_pd, aux_pd}, 6'h3F);
    chk("sinc bypass", {sinc_i, amp_byp}, 2'h1);
    chk("mult bypass", {from_mult, mult}, 6'h05);
    chk("loop band", band, 1'b1);
    hreg(1'b1, 6'h1E, 8'h00);
    chk("clock reg", q, 8'h65);
    $display("test update done");
    hreg(1'b0, 6'h1F, 8'h10);
    hreg(1'b0, 6'h26, 8'hFA);
    hreg(1'b0, 6'h27, 8'hBC);
    hreg(1'b0, 6'h1D, 8'h04);
    hreg(1'b0, 6'h20, 8'h00);
    chk("aux before", aux_data, 12'h123);
    upd(8'h01);
    chk("aux data", aux_data, 12'hABC);
    chk("aux sinc", {sinc_i, sinc_q}, 2'h2);
    chk("aux pd", {stage_pd, full_pd, aux_pd}, 6'h11);
    $display("test aux done");
    @(posedge clk_i);
    ref_on <= 1'b0;
    hreg(1'b0, 6'h1D, 8'h00);
    apb(1'b1, dop_pkg::HOST_CTRL, 32'h11);
    apb(1'b1, dop_pkg::HOST_CTRL, 32'h19);
    repeat (30) @(posedge clk_i);
    chk("no ref", stage_pd, 4'h4);
    ref_on <= 1'b1;
    upd(8'h01);
    chk("ref back", stage_pd, 4'h0);
    $display("test reference done");
    apb(1'b1, dop_pkg::HOST_CTRL, 32'h12);
    hreg(1'b0, 6'h27, 8'h55);
    chk("mode pin", pif.port_mode_select, 1'b0);
    chk("diff pin", pif.differential_clock_select, 1'b1);
    hreg(1'b1, 6'h27, 8'h00);
    chk("serial read", q, 8'h55);
    apb(1'b1, dop_pkg::HOST_CTRL, 32'h11);
    $display("test serial done");
    apb(1'b1, dop_pkg::HOST_CTRL, 32'h15);
    repeat (15) @(posedge clk_i);
    apb(1'b1, dop_pkg::HOST_CTRL, 32'h01);
    hreg(1'b1, 6'h1F, 8'h00);
    chk("mreset upd", q, 8'h01);
    hreg(1'b1, 6'h27, 8'h00);
    chk("mreset aux", q, 8'h00);
    wait_tr();
    chk("mreset out", {sinc_q, from_mult, mult, aux_data}, 19'h64123);
    $display("test master reset done");
    complete_run();
  end
endmodule
`default_nettype wire
